// ==== design/counter_interrupt_trigger.sv ====
/*
  counter-controlled interrupt trigger: counts or measures pulses on
  eight device inputs and compares with a signed setpoint over apb.
  assumes device inputs synchronous to pclk; apb master per amba rules.
*/
//
// Function
// - count one step per counting pulse
// - direction level low up, high down
// - dual inputs: one counts up, other down
// - quadrature direction from channel phase
// - full quadrature period changes count by two
// - frequency above setpoint triggers
// - frequency below setpoint triggers
// - interval selectable 10 ms, 100 ms, 1 s
// - valid range per interval, upper 5000 Hz
// - four result bits from interrupt routine
// - count reaching setpoint triggers
// - count clear high zeroes count
// - setpoint is signed 32-bit
// - activate input gates when required
`timescale 1ns/1ns
module counter_interrupt_trigger #(
  parameter int unsigned IVL_SHORT_CYC_P = cit_pkg::IVL_SHORT_CYC,
  parameter int unsigned IVL_MID_CYC_P   = cit_pkg::IVL_MID_CYC,
  parameter int unsigned IVL_LONG_CYC_P  = cit_pkg::IVL_LONG_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [7:0]         device_in,
  input  wire logic               activate,
  input  wire logic               count_clear,
  output logic signed [31:0]      current_count_output,
  output logic                    result_bit_one,
  output logic                    result_bit_two,
  output logic                    result_bit_three,
  output logic                    result_bit_four,
  output logic                    trigger_pulse
);
  import cit_pkg::*;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (IVL_SHORT_CYC_P < 1 || IVL_SHORT_CYC_P > IVL_MID_CYC_P || IVL_MID_CYC_P > IVL_LONG_CYC_P ||
      IVL_LONG_CYC_P >= 2**24) begin : g_bad_ivl
    $error("interval lengths must rise and fit 24 bits");
  end
  if (CLK_FREQ_HZ < 4 * MAX_PULSE_HZ) begin : g_bad_clk
    $error("clock too slow for the fastest pulse train");
  end

  // picks one device input by its 3-bit number
  function automatic logic sel_bit(input logic [7:0] vec, input logic [2:0] idx);
    return vec[idx];
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ctrl_type             ctrl_ff;        // mode, interval, input numbers
  logic signed [31:0]   setpoint_ff;    // reference_setpoint
  logic signed [31:0]   count_ff;       // block_count_value
  logic [31:0]          freq_ff;        // last measured frequency in Hz
  logic [15:0]          edges_ff;       // edges in running interval
  logic [23:0]          ivl_cnt_ff;     // cycles into running interval
  logic                 valid_ff;       // last frequency in range
  logic                 trig_flag_ff;   // sticky trigger flag
  logic                 trig_ff;        // one-cycle trigger
  logic [RESULT_W-1:0]  result_ff;      // result bits
  logic [31:0]          prdata_ff;      // apb read data
  logic                 pready_ff;      // apb ready
  logic                 pslverr_ff;     // apb error
  step_type             step;           // pulses from the step unit

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire setup_ph   = psel & ~penable;
  wire access_ok  = psel & penable & pready_ff;
  wire wr_en      = access_ok & pwrite;
  wire sel_ctrl   = paddr == OFS_CTRL;
  wire sel_setpt  = paddr == OFS_SETPOINT;
  wire sel_count  = paddr == OFS_COUNT;
  wire sel_freq   = paddr == OFS_FREQ;
  wire sel_status = paddr == OFS_STATUS;
  wire sel_result = paddr == OFS_RESULT;
  wire addr_ok    = sel_ctrl | sel_setpt | sel_count | sel_freq | sel_status | sel_result;
  wire wr_ctrl    = wr_en & sel_ctrl;
  wire wr_setpt   = wr_en & sel_setpt;
  wire wr_status  = wr_en & sel_status;
  wire wr_result  = wr_en & sel_result;

  // status word
  wire active = ~ctrl_ff.en_required | activate;
  wire [31:0] status_word = {29'h0, active, valid_ff, trig_flag_ff};

  // read mux
  wire [31:0] rd_word = sel_ctrl   ? ctrl_ff :
                        sel_setpt  ? setpoint_ff :
                        sel_count  ? count_ff :
                        sel_freq   ? freq_ff :
                        sel_status ? status_word :
                        sel_result ? {28'h0, result_ff} : 32'h0000_0000;

  // ------------------------------------------------------------
  // counting path
  // ------------------------------------------------------------
  wire count_mode = (ctrl_ff.mode == MODE_EXT_DIR) | (ctrl_ff.mode == MODE_DUAL) |
                    (ctrl_ff.mode == MODE_INCR);
  wire freq_mode  = (ctrl_ff.mode == MODE_FREQ_ABOVE) | (ctrl_ff.mode == MODE_FREQ_BELOW);
  wire pulse_a    = sel_bit(device_in, ctrl_ff.cnt_sel);
  wire pulse_b    = sel_bit(device_in, ctrl_ff.aux_sel);

  // step unit: mode decode of the two selected inputs
  pulse_step_unit u_step (
    .pclk    (pclk),
    .presetn (presetn),
    .mode    (ctrl_ff.mode),
    .enable  (active),
    .pulse_a (pulse_a),
    .pulse_b (pulse_b),
    .step    (step)
  );

  // simultaneous up and down cancel out
  wire step_any = active & count_mode & (step.up ^ step.dn) & ~count_clear;
  wire signed [31:0] step_val  = step.up ? 32'sh0000_0001 : -32'sh0000_0001;
  wire signed [31:0] nxt_count = count_clear ? 32'sh0000_0000 :
                                 step_any ? count_ff + step_val :
                                 count_ff;
  wire hit_count = step_any & (nxt_count == setpoint_ff);

  // ------------------------------------------------------------
  // frequency path
  // ------------------------------------------------------------
  wire [23:0] ivl_len = (ctrl_ff.ivl == IVL_SHORT) ? 24'(IVL_SHORT_CYC_P) :
                        (ctrl_ff.ivl == IVL_MID)   ? 24'(IVL_MID_CYC_P) : 24'(IVL_LONG_CYC_P);
  wire        meas_on  = active & freq_mode;
  // at or past the end: a switch to a shorter interval must not run on to wrap
  wire        ivl_end  = meas_on & (ivl_cnt_ff >= ivl_len - 24'h00_0001);
  wire [31:0] nxt_freq = 32'(edges_ff) * freq_scale(ctrl_ff.ivl);
  wire        freq_ok  = (nxt_freq >= freq_min(ctrl_ff.ivl)) & (nxt_freq <= MAX_HZ);
  wire        f_above  = $signed({1'b0, nxt_freq}) > 33'(setpoint_ff);
  wire        f_below  = $signed({1'b0, nxt_freq}) < 33'(setpoint_ff);
  wire        freq_hit = ivl_end & freq_ok &
                         (((ctrl_ff.mode == MODE_FREQ_ABOVE) & f_above) |
                          ((ctrl_ff.mode == MODE_FREQ_BELOW) & f_below));
  wire [15:0] edges_sum = (edges_ff == 16'hffff) ? edges_ff : edges_ff + 16'(step.edge_a);
  wire [15:0] nxt_edges = !meas_on ? 16'h0000 : ivl_end ? 16'(step.edge_a) : edges_sum;
  wire [23:0] nxt_ivl   = (!meas_on || ivl_end) ? 24'h00_0000 : ivl_cnt_ff + 24'h00_0001;

  // trigger and its sticky copy, set wins over clear
  wire nxt_trig = hit_count | freq_hit;
  wire nxt_flag = nxt_trig | (trig_flag_ff & ~(wr_status & pwdata[ST_TRIG_BIT]));

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // apb answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup_ph;
      pslverr_ff <= setup_ph & ~addr_ok;
      prdata_ff  <= setup_ph ? rd_word : prdata_ff;
    end
  end

  // software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= CTRL_RESET;
      setpoint_ff <= SETPT_RESET;
      result_ff   <= '0;
    end else begin
      if (wr_ctrl)   ctrl_ff     <= pwdata & CTRL_WMASK;
      if (wr_setpt)  setpoint_ff <= pwdata;
      if (wr_result) result_ff   <= pwdata[RESULT_W-1:0];
    end
  end

  // counting and measuring state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff     <= 32'sh0000_0000;
      edges_ff     <= 16'h0000;
      ivl_cnt_ff   <= 24'h00_0000;
      freq_ff      <= 32'h0000_0000;
      valid_ff     <= 1'b0;
      trig_ff      <= 1'b0;
      trig_flag_ff <= 1'b0;
    end else begin
      count_ff     <= nxt_count;
      edges_ff     <= nxt_edges;
      ivl_cnt_ff   <= nxt_ivl;
      freq_ff      <= ivl_end ? nxt_freq : freq_ff;
      valid_ff     <= ivl_end ? freq_ok : valid_ff;
      trig_ff      <= nxt_trig;
      trig_flag_ff <= nxt_flag;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign current_count_output = count_ff;
  assign result_bit_one       = result_ff[0];
  assign result_bit_two       = result_ff[1];
  assign result_bit_three     = result_ff[2];
  assign result_bit_four      = result_ff[3];
  assign trigger_pulse        = trig_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    count_clear |=> current_count_output == 32'sh0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");

  property p_up_step;
    @(posedge pclk) disable iff (!presetn)
    (active && count_mode && step.up && !step.dn && !count_clear) |=>
      current_count_output == $past(current_count_output) + 32'sh0000_0001;
  endproperty
  a_up_step: assert property (p_up_step) else $error("up step lost");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    (step_any && step.up && count_ff == 32'sh7fff_ffff) |=> count_ff == 32'sh8000_0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");

  property p_reach;
    @(posedge pclk) disable iff (!presetn)
    (step_any && nxt_count == setpoint_ff) |=> trigger_pulse && trig_flag_ff;
  endproperty
  a_reach: assert property (p_reach) else $error("setpoint reached without trigger");

  property p_hold_inactive;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_ff.en_required && !activate && !count_clear) |=> $stable(count_ff) && !trigger_pulse;
  endproperty
  a_hold_inactive: assert property (p_hold_inactive) else $error("counted while inactive");

  property p_above;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_ff.mode == MODE_FREQ_ABOVE && ivl_end && freq_ok && f_above) |=> trigger_pulse;
  endproperty
  a_above: assert property (p_above) else $error("frequency above missed");

  property p_below;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_ff.mode == MODE_FREQ_BELOW && ivl_end && freq_ok && f_below) |=> trigger_pulse;
  endproperty
  a_below: assert property (p_below) else $error("frequency below missed");

  property p_freq_once;
    @(posedge pclk) disable iff (!presetn)
    (freq_mode && trigger_pulse) |-> $past(ivl_end);
  endproperty
  a_freq_once: assert property (p_freq_once) else $error("frequency trigger off interval end");

  property p_range;
    @(posedge pclk) disable iff (!presetn)
    ivl_end |=> valid_ff == (freq_ff >= freq_min($past(ctrl_ff.ivl)) && freq_ff <= MAX_HZ);
  endproperty
  a_range: assert property (p_range) else $error("range flag wrong");

  property p_result;
    @(posedge pclk) disable iff (!presetn)
    wr_result |=> {result_bit_four, result_bit_three, result_bit_two, result_bit_one} == $past(pwdata[3:0]);
  endproperty
  a_result: assert property (p_result) else $error("result bits not updated");

  c_count_hit: cover property (@(posedge pclk) disable iff (!presetn) count_mode && trigger_pulse);
  c_freq_hit:  cover property (@(posedge pclk) disable iff (!presetn) freq_mode && trigger_pulse);
  c_clear:     cover property (@(posedge pclk) disable iff (!presetn) count_clear ##1 step_any);
endmodule

// ==== include/cit_pkg.sv ====
/*
  shared constants, field layouts and carrier types for the counter
  interrupt trigger: register offsets, mode codes, interval timing.
  assumes a single 10 MHz clock and an apb register port.
*/
package cit_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_FREQ_HZ  = 10_000_000;   // pclk rate
  localparam int MAX_PULSE_HZ = 5000;         // fastest pulse train served
  localparam int IVL_SHORT_MS = 10;           // shortest measuring interval
  localparam int IVL_MID_MS   = 100;          // middle measuring interval
  localparam int IVL_LONG_MS  = 1000;         // longest measuring interval
  localparam int IVL_SHORT_CYC = CLK_FREQ_HZ / 1000 * IVL_SHORT_MS;
  localparam int IVL_MID_CYC   = CLK_FREQ_HZ / 1000 * IVL_MID_MS;
  localparam int IVL_LONG_CYC  = CLK_FREQ_HZ / 1000 * IVL_LONG_MS;
  localparam logic [31:0] MIN_HZ_SHORT = 32'h0000_01f4;  // 500 Hz
  localparam logic [31:0] MIN_HZ_MID   = 32'h0000_0032;  // 50 Hz
  localparam logic [31:0] MIN_HZ_LONG  = 32'h0000_0005;  // 5 Hz
  localparam logic [31:0] MAX_HZ       = 32'h0000_1388;  // 5000 Hz
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SETPOINT = 8'h04;
  localparam logic [7:0] OFS_COUNT    = 8'h08;
  localparam logic [7:0] OFS_FREQ     = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_RESULT   = 8'h14;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int ST_TRIG_BIT   = 0;           // sticky trigger flag, w1c
  localparam int ST_VALID_BIT  = 1;           // last frequency in range
  localparam int ST_ACTIVE_BIT = 2;           // block running
  localparam int RESULT_W      = 4;           // result bit count
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK  = 32'h0001_7737;
  localparam logic [31:0] SETPT_RESET = 32'h0000_0000;
  // ------------------------------------------------------------
  // mode and interval codes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_EXT_DIR    = 3'h0;
  localparam logic [2:0] MODE_DUAL       = 3'h1;
  localparam logic [2:0] MODE_INCR       = 3'h2;
  localparam logic [2:0] MODE_FREQ_ABOVE = 3'h3;
  localparam logic [2:0] MODE_FREQ_BELOW = 3'h4;
  localparam logic [1:0] IVL_SHORT = 2'h0;
  localparam logic [1:0] IVL_MID   = 2'h1;
  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [14:0] rsv_hi;       // reads zero
    logic        en_required;  // activate input gates the block
    logic        rsv_c;
    logic [2:0]  aux_sel;      // direction / down / channel b input
    logic        rsv_b;
    logic [2:0]  cnt_sel;      // counting / channel a input
    logic [1:0]  rsv_a;
    logic [1:0]  ivl;          // measuring interval code
    logic        rsv_m;
    logic [2:0]  mode;         // operating mode code
  } ctrl_type;

  typedef struct packed {
    logic up;                  // one step up
    logic dn;                  // one step down
    logic edge_a;              // rising edge on the counting input
  } step_type;

  // frequency per edge for an interval code
  function automatic logic [31:0] freq_scale(input logic [1:0] ivl);
    return (ivl == IVL_SHORT) ? 32'(1000 / IVL_SHORT_MS) :
           (ivl == IVL_MID)   ? 32'(1000 / IVL_MID_MS) : 32'(1000 / IVL_LONG_MS);
  endfunction

  // lowest valid frequency for an interval code
  function automatic logic [31:0] freq_min(input logic [1:0] ivl);
    return (ivl == IVL_SHORT) ? MIN_HZ_SHORT : (ivl == IVL_MID) ? MIN_HZ_MID : MIN_HZ_LONG;
  endfunction
endpackage

// ==== design/pulse_step_unit.sv ====
/*
  turns the two selected device inputs into up, down and edge pulses
  according to the counting mode.
  assumes inputs synchronous to pclk; outputs lag the inputs by one edge.
*/
`timescale 1ns/1ns
module pulse_step_unit (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [2:0]    mode,
  input  wire logic          enable,
  input  wire logic          pulse_a,
  input  wire logic          pulse_b,
  output cit_pkg::step_type  step
);
  import cit_pkg::*;

  // ------------------------------------------------------------
  // history and decode
  // ------------------------------------------------------------
  logic     a_ff;          // last level of input a
  logic     b_ff;          // last level of input b
  step_type step_ff;       // registered pulses
  step_type nxt_step;

  wire rise_a = pulse_a & ~a_ff;
  wire rise_b = pulse_b & ~b_ff;
  wire edge_a = pulse_a ^ a_ff;
  wire phase  = pulse_a ^ pulse_b;   // a leads b while high on a edge

  // per-mode step decode
  wire ext_up  = rise_a & ~pulse_b;
  wire ext_dn  = rise_a & pulse_b;
  wire incr_up = edge_a & phase;
  wire incr_dn = edge_a & ~phase;

  wire nxt_up = enable & ((mode == MODE_EXT_DIR) ? ext_up :
                          (mode == MODE_DUAL)    ? rise_a :
                          (mode == MODE_INCR)    ? incr_up : 1'b0);
  wire nxt_dn = enable & ((mode == MODE_EXT_DIR) ? ext_dn :
                          (mode == MODE_DUAL)    ? rise_b :
                          (mode == MODE_INCR)    ? incr_dn : 1'b0);
  // one driver for the whole pulse word
  assign nxt_step = {nxt_up, nxt_dn, enable & rise_a};
  assign step = step_ff;

  // history and pulse registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_ff    <= 1'b0;
      b_ff    <= 1'b0;
      step_ff <= '0;
    end else begin
      a_ff    <= pulse_a;
      b_ff    <= pulse_b;
      step_ff <= nxt_step;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_ext_dir;
    @(posedge pclk) disable iff (!presetn)
    (enable && mode == MODE_EXT_DIR && rise_a) |=> (step.dn == $past(pulse_b)) && (step.up != step.dn);
  endproperty
  a_ext_dir: assert property (p_ext_dir) else $error("direction level not obeyed");

  property p_dual;
    @(posedge pclk) disable iff (!presetn)
    (enable && mode == MODE_DUAL && rise_b) |=> step.dn;
  endproperty
  a_dual: assert property (p_dual) else $error("down input did not step");

  property p_incr_dir;
    @(posedge pclk) disable iff (!presetn)
    (enable && mode == MODE_INCR && edge_a) |=> (step.up == $past(phase)) && (step.up ^ step.dn);
  endproperty
  a_incr_dir: assert property (p_incr_dir) else $error("quadrature direction wrong");

  property p_incr_b_only;
    @(posedge pclk) disable iff (!presetn)
    (mode == MODE_INCR && !edge_a) |=> !step.up && !step.dn;
  endproperty
  a_incr_b_only: assert property (p_incr_b_only) else $error("step without channel a edge");

  c_incr_up: cover property (@(posedge pclk) disable iff (!presetn) mode == MODE_INCR ##1 step.up);
endmodule

// ==== tb/pulse_source.sv ====
/* pulse source and quadrature encoder model on the eight device inputs.
   assumes the bench clock; levels change right after rising edges. */
`timescale 1ns/1ns
module pulse_source (
  input  wire logic       pclk,
  output logic      [7:0] device_in
);
  // inputs idle low
  initial device_in = 8'h00;
  // set one level, hold it two cycles
  task put(input int i, input logic v);
    @(posedge pclk);
    device_in[i] <= v;
    @(posedge pclk);
  endtask
  // one pulse, two cycles high, two low
  task pulse(input int i);
    put(i, 1'b1);
    put(i, 1'b0);
  endtask
  // one encoder period on inputs ia and ib, a leads b when up
  task quad(input logic up, input int ia, input int ib);
    put(up ? ia : ib, 1'b1);
    put(up ? ib : ia, 1'b1);
    put(up ? ia : ib, 1'b0);
    put(up ? ib : ia, 1'b0);
  endtask
endmodule

// ==== tb/counter_interrupt_trigger_tb_top.sv ====
/* self-checking bench for the counter interrupt trigger.
   assumes short interval parameters 100/1000/10000 cycles. */
`timescale 1ns/1ns
module counter_interrupt_trigger_tb_top;
  import cit_pkg::*;
  // one counting case: control word, a and b input numbers, direction level, stimulus, count
  typedef struct packed {logic [31:0] ctrl; logic [2:0] ia; logic [2:0] ib; logic dir; logic [1:0] op;
    logic [31:0] exp;} row_type;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic               activate, count_clear, trigger_pulse, r1, r2, r3, r4;
  logic        [7:0]  paddr, device_in;
  logic        [31:0] pwdata, prdata, rd, t;
  logic signed [31:0] current_count_output;
  int                 miscompares, n_tests, n_trig;
  // ext-dir low/high, dual up/down, encoder up/down; input numbers spread over seven of the eight, all but number 4
  row_type rows [6] = '{
    '{32'h7200, 3'h2, 3'h7, 1'b0, 2'h0, 32'h2},
    '{32'h5300, 3'h3, 3'h5, 1'b1, 2'h0, 32'hffff_fffe},
    '{32'h1001, 3'h0, 3'h1, 1'b0, 2'h0, 32'h2},
    '{32'h6101, 3'h1, 3'h6, 1'b0, 2'h1, 32'hffff_fffe},
    '{32'h1002, 3'h0, 3'h1, 1'b0, 2'h2, 32'h4},
    '{32'h3202, 3'h2, 3'h3, 1'b0, 2'h3, 32'hffff_fffc}};
  counter_interrupt_trigger #(.IVL_SHORT_CYC_P(100), .IVL_MID_CYC_P(1000), .IVL_LONG_CYC_P(10000))
    counter_interrupt_trigger_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_in(device_in), .activate(activate), .count_clear(count_clear),
    .current_count_output(current_count_output), .result_bit_one(r1), .result_bit_two(r2),
    .result_bit_three(r3), .result_bit_four(r4), .trigger_pulse(trigger_pulse));
  pulse_source pulse_source_inst (.pclk(pclk), .device_in(device_in));
  // clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // trigger event counter
  always @(posedge pclk) if (trigger_pulse === 1'b1) n_trig <= n_trig + 1;
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task test_done;
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // two-cycle count clear
  task clr;
    @(posedge pclk);
    count_clear <= 1'b1;
    repeat (2) @(posedge pclk);
    count_clear <= 1'b0;
  endtask
  // frequency case: does a pulse train of n pulses trigger
  task frq(input logic [31:0] c, input logic [31:0] sp, input int n, input logic hit);
    // leave frequency mode first so the interval starts afresh
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_SETPOINT, sp);
    apb(1'b1, OFS_CTRL, c);
    t = n_trig;
    repeat (n) pulse_source_inst.pulse(0);
    chk(32'(n_trig != t), 32'(hit));
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    test_done;
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, activate, count_clear} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    chk(32'(current_count_output), 32'h0);
    foreach (rows[k]) begin
      apb(1'b1, OFS_CTRL, rows[k].ctrl);
      pulse_source_inst.put(rows[k].ib, rows[k].dir);
      clr;
      chk(32'(current_count_output), 32'h0);
      repeat (2) begin
        if (rows[k].op[1]) pulse_source_inst.quad(~rows[k].op[0], rows[k].ia, rows[k].ib);
        else pulse_source_inst.pulse(rows[k].op[0] ? rows[k].ib : rows[k].ia);
      end
      apb(1'b0, OFS_COUNT, 32'h0);
      chk(rd, rows[k].exp);
    end
    // negative setpoint reached by counting down
    apb(1'b1, OFS_SETPOINT, 32'hffff_fffe);
    apb(1'b1, OFS_CTRL, 32'h4000);
    pulse_source_inst.put(4, 1'b1);
    clr;
    t = n_trig;
    repeat (2) pulse_source_inst.pulse(0);
    repeat (3) @(posedge pclk);
    chk(32'(n_trig) - t, 32'h1);
    // activation required, held low then high
    apb(1'b1, OFS_CTRL, 32'h1_4000);
    pulse_source_inst.pulse(0);
    chk(32'(current_count_output), 32'hffff_fffe);
    activate <= 1'b1;
    pulse_source_inst.pulse(0);
    chk(32'(current_count_output), 32'hffff_fffd);
    // result bits and an unmapped read
    apb(1'b1, OFS_RESULT, 32'ha);
    // the write lands on the edge the task returns at
    @(posedge pclk);
    chk(32'({r4, r3, r2, r1}), 32'ha);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // about 2500 Hz on input one
    frq(32'h3, 32'd1000, 60, 1'b1);
    // input two selected, pulses on input one: 0 Hz is out of range
    frq(32'h104, 32'd1000, 60, 1'b0);
    frq(32'h4, 32'd1000, 60, 1'b0);
    frq(32'h14, 32'd5000, 300, 1'b1);
    frq(32'h23, 32'h0000_03e8, 2550, 1'b1);
    // last interval held 2500 edges at scale one
    apb(1'b0, OFS_FREQ, 32'h0);
    chk(rd, 32'h0000_09c4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_0007);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_0006);
    // reset in mid-run: count and control back to reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(current_count_output), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    test_done;
  end
endmodule
